/* File: core/embi_top.sv */
// Contract
// - Clock output toggles at half oscillator rate
// - Dynamic width: pin chooses 16 or 8 bit
// - Dynamic width off: every cycle 8 bit
// - Rising event input vectors to fixed location
// - Fetch kind high for instruction reads
// - Fetch kind only during external access
// - Select high keeps ROM range internal
// - Select input feeds programming mode entry
// - Strobe is latch enable or address valid
// - Address valid returns high at cycle end
// - Read strobe only in external reads
// - Write pin: every write or even byte
// - High enable low for upper byte writes
// - High write low for odd byte writes
// - Ready low stretches the cycle
// - Ready ignored outside external access
// - Reset pin input, optional open drain pull
// - Hold granted after bus released
// - Bus request while cycle pending
//
// Our own choices: the Wishbone slave port and the placing of the registers.
module embi_top (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Pins in
    input  wire logic        bus_width_i,
    input  wire logic        ready_i,
    input  wire logic        nmi_i,
    input  wire logic        onchip_rom_select_i,
    input  wire logic        prog_pin_i,
    input  wire logic        reset_pin_i,
    input  wire logic        hold_req_i,
    input  wire logic [15:0] ad_i,
    // Pins out
    output logic             clock_output_o,
    output logic             addr_strobe_o,
    output logic             read_low_o,
    output logic             write_low_o,
    output logic             high_pin_o,
    output logic             fetch_kind_flag_o,
    output logic             bus_hold_grant_o,
    output logic             bus_request_out_o,
    output logic             reset_pin_o,
    output logic             reset_pin_oe_o,
    output logic [15:0]      ad_o,
    output logic [15:0]      ad_oe_o,
    // Core side
    output logic             nmi_vector_o,
    output logic [15:0]      vector_addr_o,
    output logic             prog_mode_o,
    output logic             device_reset_o
);
    typedef struct packed {
        embi_pkg::embi_state_t fsm;
        logic [7:0]  cfg;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        wr;
        logic        fetch;
        logic        word;
        logic        wide;
        logic        internal;
        logic        pending;
        logic        dev_rst;
        logic        nmi_last;
        logic        nmi_pulse;
        logic        prog;
        logic [31:0] dat;
        logic        ack;
        logic        as;
        logic        rd_n;
        logic        wr_n;
        logic        hi_n;
        logic        fk;
        logic        grant;
        logic        bus_request_out;
        logic [15:0] ado;
        logic [15:0] adoe;
    } embi_top_t;

    embi_top_t st_reg;
    embi_top_t st_next;

    logic [4:0] pin_lvl;
    logic       bw_s;
    logic       rdy_s;
    logic       nmi_s;
    logic       hold_s;
    logic       rst_s;

    embi_sync #(.WIDTH(5)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        // Reset pin inverted so the synchroniser's cleared state means idle
        .async_i ({bus_width_i, ready_i, nmi_i, hold_req_i, !reset_pin_i}),
        .level_o (pin_lvl)
    );
    assign {bw_s, rdy_s, nmi_s, hold_s, rst_s} = pin_lvl;

    embi_clkdiv u_clk (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .clock_output_o (clock_output_o)
    );

    function automatic logic in_rom(input logic [15:0] a);
        in_rom = (a >= embi_pkg::ROM_LOW) && (a <= embi_pkg::ROM_HIGH);
    endfunction : in_rom

    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                          input logic en);
        merge8 = en ? nw : old;
    endfunction : merge8

    logic wb_req;
    logic adv_mode;
    assign wb_req   = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign adv_mode = st_reg.cfg[embi_pkg::CFG_ADDR_ADV];

    always_comb
    begin
        st_next     = st_reg;
        st_next.ack = wb_req;
        st_next.dev_rst = rst_s;
        // Event input edge after synchroniser
        st_next.nmi_last  = nmi_s;
        st_next.nmi_pulse = nmi_s && !st_reg.nmi_last;
        // Programming mode needs select low and the program pin
        st_next.prog = !onchip_rom_select_i && prog_pin_i;

        if (wb_req)
        begin
            case (wb_adr_i)
                embi_pkg::OFF_CONFIG:  st_next.dat = {24'h0, st_reg.cfg};
                embi_pkg::OFF_STATUS:  st_next.dat = {26'h0, st_reg.prog, st_reg.wide,
                                                      st_reg.internal, st_reg.grant,
                                                      st_reg.pending, st_reg.fsm != 3'b000};
                embi_pkg::OFF_REQUEST: st_next.dat = {12'h0, st_reg.word, st_reg.fetch,
                                                      st_reg.wr, 1'b0, st_reg.addr};
                embi_pkg::OFF_DATA:    st_next.dat = {st_reg.rdata, st_reg.wdata};
                default:               st_next.dat = 32'h0;
            endcase
            if (wb_we_i)
            begin
                case (wb_adr_i)
                    embi_pkg::OFF_CONFIG:
                        st_next.cfg = merge8(st_reg.cfg, wb_dat_i[7:0], wb_sel_i[0]);
                    embi_pkg::OFF_REQUEST:
                    begin
                        // New request ignored while one is pending
                        if (!st_reg.pending && wb_sel_i[0] && wb_dat_i[embi_pkg::REQ_GO])
                        begin
                            st_next.pending = 1'b1;
                            st_next.wr      = wb_dat_i[embi_pkg::REQ_WRITE];
                            st_next.fetch   = wb_dat_i[embi_pkg::REQ_FETCH];
                            st_next.word    = wb_dat_i[embi_pkg::REQ_WORD];
                            st_next.addr    = wb_dat_i[31:16];
                        end
                    end
                    embi_pkg::OFF_DATA:
                    begin
                        st_next.wdata[7:0]  = merge8(st_reg.wdata[7:0], wb_dat_i[7:0],
                                                     wb_sel_i[0]);
                        st_next.wdata[15:8] = merge8(st_reg.wdata[15:8], wb_dat_i[15:8],
                                                     wb_sel_i[1]);
                    end
                    default: ;
                endcase
            end
        end

        st_next.bus_request_out = st_next.pending;
        case (st_reg.fsm)
            embi_pkg::EMBI_IDLE:
            begin
                st_next.as   = adv_mode;
                st_next.rd_n = 1'b1;
                st_next.wr_n = 1'b1;
                st_next.hi_n = 1'b1;
                st_next.fk   = 1'b0;
                st_next.adoe = 16'h0;
                if (hold_s)
                begin
                    st_next.fsm   = embi_pkg::EMBI_HOLD;
                    st_next.grant = 1'b1;
                end
                else if (st_reg.pending)
                begin
                    st_next.internal = onchip_rom_select_i && in_rom(st_reg.addr);
                    // Width chosen per cycle when dynamic width is on
                    st_next.wide = st_reg.cfg[embi_pkg::CFG_DYN_WIDTH] && bw_s;
                    if (onchip_rom_select_i && in_rom(st_reg.addr))
                    begin
                        st_next.pending = 1'b0;
                        st_next.rdata   = 16'hffff;
                    end
                    else
                    begin
                        st_next.fsm  = embi_pkg::EMBI_ADDR;
                        st_next.as   = !adv_mode;
                        st_next.ado  = st_reg.addr;
                        st_next.adoe = 16'hffff;
                        st_next.fk   = st_reg.fetch && !st_reg.wr;
                    end
                end
            end
            embi_pkg::EMBI_ADDR:
            begin
                st_next.fsm = embi_pkg::EMBI_DATA;
                // Latch enable drops, address valid stays low all cycle
                st_next.as  = 1'b0;
                if (st_reg.wr)
                begin
                    st_next.ado  = st_reg.wide ? st_reg.wdata
                                              : {st_reg.wdata[7:0], st_reg.wdata[7:0]};
                    st_next.wr_n = st_reg.cfg[embi_pkg::CFG_WR_LOW] ? st_reg.addr[0] : 1'b0;
                    st_next.hi_n = st_reg.cfg[embi_pkg::CFG_HI_WRITE]
                                 ? !(st_reg.addr[0] || (st_reg.word && st_reg.wide))
                                 : !(st_reg.wide && (st_reg.word || st_reg.addr[0]));
                end
                else
                begin
                    st_next.adoe = 16'h0;
                    st_next.rd_n = 1'b0;
                end
            end
            embi_pkg::EMBI_DATA:
            begin
                // Waits only here, so ready has no effect elsewhere
                if (rdy_s)
                begin
                    st_next.fsm = embi_pkg::EMBI_END;
                    if (!st_reg.wr)
                    begin
                        st_next.rdata = st_reg.wide ? ad_i : {8'h0, ad_i[7:0]};
                    end
                    st_next.rd_n = 1'b1;
                    st_next.wr_n = 1'b1;
                    st_next.hi_n = 1'b1;
                end
            end
            embi_pkg::EMBI_END:
            begin
                st_next.fsm     = embi_pkg::EMBI_IDLE;
                st_next.as      = adv_mode;
                st_next.fk      = 1'b0;
                st_next.adoe    = 16'h0;
                st_next.pending = 1'b0;
                st_next.bus_request_out    = 1'b0;
            end
            embi_pkg::EMBI_HOLD:
            begin
                if (!hold_s)
                begin
                    st_next.fsm   = embi_pkg::EMBI_IDLE;
                    st_next.grant = 1'b0;
                end
            end
            default: st_next.fsm = embi_pkg::EMBI_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg      <= '0;
            st_reg.cfg  <= embi_pkg::CONFIG_RESET;
            st_reg.rd_n <= 1'b1;
            st_reg.wr_n <= 1'b1;
            st_reg.hi_n <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o          = st_reg.dat;
    assign wb_ack_o          = st_reg.ack;
    assign addr_strobe_o     = st_reg.as;
    assign read_low_o        = st_reg.rd_n;
    assign write_low_o       = st_reg.wr_n;
    assign high_pin_o        = st_reg.hi_n;
    assign fetch_kind_flag_o = st_reg.fk;
    assign bus_hold_grant_o  = st_reg.grant;
    assign bus_request_out_o = st_reg.bus_request_out;
    assign ad_o              = st_reg.ado;
    assign ad_oe_o           = st_reg.adoe;
    assign nmi_vector_o      = st_reg.nmi_pulse;
    assign vector_addr_o     = embi_pkg::NMI_VECTOR;
    assign prog_mode_o       = st_reg.prog;
    // Software pull via config bit; reset pin level resets the device
    assign reset_pin_o       = 1'b0;
    assign reset_pin_oe_o    = st_reg.cfg[embi_pkg::CFG_RST_OUT];
    assign device_reset_o    = st_reg.dev_rst;

    a_read_only_ext: assert property (@(posedge clk_i) disable iff (rst_i)
        !read_low_o |-> st_reg.fsm == embi_pkg::EMBI_DATA && !st_reg.wr)
        else $error("read strobe outside external read");
    a_write_only_ext: assert property (@(posedge clk_i) disable iff (rst_i)
        !write_low_o |-> st_reg.fsm == embi_pkg::EMBI_DATA && st_reg.wr)
        else $error("write strobe outside external write");
    a_fetch_in_access: assert property (@(posedge clk_i) disable iff (rst_i)
        fetch_kind_flag_o |-> st_reg.fsm != embi_pkg::EMBI_IDLE)
        else $error("fetch flag outside access");
    a_narrow_when_static: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.fsm == embi_pkg::EMBI_DATA && !st_reg.cfg[embi_pkg::CFG_DYN_WIDTH]
        |-> !st_reg.wide)
        else $error("wide cycle without dynamic width");
    a_wait_on_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.fsm == embi_pkg::EMBI_DATA && !rdy_s |=> st_reg.fsm == embi_pkg::EMBI_DATA)
        else $error("cycle ended without ready");
    a_adv_end_high: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.fsm == embi_pkg::EMBI_END && adv_mode |=> addr_strobe_o)
        else $error("address valid not high after cycle");
    a_rom_stays_in: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.fsm == embi_pkg::EMBI_ADDR |-> !st_reg.internal)
        else $error("internal access went external");
    a_nmi_pulse_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        nmi_vector_o |-> $past(nmi_s) && !$past(st_reg.nmi_last))
        else $error("vector pulse without rising edge");
    a_grant_no_bus: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_hold_grant_o |-> ad_oe_o == 16'h0 && read_low_o && write_low_o)
        else $error("grant while driving bus");
endmodule : embi_top

/* File: core/embi_pkg.sv */
package embi_pkg;
    // Register byte offsets
    localparam logic [3:0] OFF_CONFIG  = 4'h0;
    localparam logic [3:0] OFF_STATUS  = 4'h4;
    localparam logic [3:0] OFF_REQUEST = 4'h8;
    localparam logic [3:0] OFF_DATA    = 4'hc;

    // Configuration bit positions
    localparam int CFG_DYN_WIDTH = 1;
    localparam int CFG_ADDR_ADV  = 2;
    localparam int CFG_WR_LOW    = 3;
    localparam int CFG_HI_WRITE  = 4;
    localparam int CFG_RST_OUT   = 5;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // Request register bit positions
    localparam int REQ_GO    = 0;
    localparam int REQ_WRITE = 1;
    localparam int REQ_FETCH = 2;
    localparam int REQ_WORD  = 3;

    // On-chip ROM window
    localparam logic [15:0] ROM_LOW  = 16'h2000;
    localparam logic [15:0] ROM_HIGH = 16'h9fff;
    localparam logic [15:0] NMI_VECTOR = 16'h203e;

    typedef enum logic [2:0] {
        EMBI_IDLE  = 3'b000,
        EMBI_ADDR  = 3'b001,
        EMBI_DATA  = 3'b010,
        EMBI_END   = 3'b011,
        EMBI_HOLD  = 3'b100
    } embi_state_t;
endpackage : embi_pkg

/* File: core/embi_sync.sv */
module embi_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } embi_sync_t;

    embi_sync_t st_reg;
    embi_sync_t st_next;

    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = async_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // A change counts once stages two and three agree
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.lvl[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.lvl;
endmodule : embi_sync

/* File: core/embi_clkdiv.sv */
module embi_clkdiv (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      clock_output_o
);
    typedef struct packed {
        logic half;
    } embi_clkdiv_t;

    embi_clkdiv_t st_reg;
    embi_clkdiv_t st_next;

    always_comb
    begin
        st_next      = st_reg;
        st_next.half = ~st_reg.half;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign clock_output_o = st_reg.half;

    a_clock_half_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) == 1'b0 |-> clock_output_o != $past(clock_output_o))
        else $error("clock output did not toggle");
endmodule : embi_clkdiv

/* File: testbench/embi_mem_model.sv */
module embi_mem_model (
    // Clock
    input  wire logic        clk_i,
    // From device
    input  wire logic        addr_strobe_i,
    input  wire logic        read_low_i,
    input  wire logic        write_low_i,
    input  wire logic        high_pin_i,
    input  wire logic        fetch_kind_i,
    input  wire logic [15:0] ad_i,
    // Behaviour
    input  wire logic [3:0]  wait_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        wide_i,
    // To device
    output logic             ready_o,
    output logic             bus_width_o,
    output logic [15:0]      ad_o = 16'h5a5a
);
    timeunit 1ns;
    timeprecision 1ns;

    int          cycles  = 0;
    int          low_len = 0;
    int          last_len;
    logic        act;
    logic        act_d;
    logic        saw_wl, saw_hi, saw_rd, as_prev, as_addr, fk_first, fk_const;
    logic [15:0] prev_ad, addr;

    assign act         = !read_low_i || !write_low_i || !high_pin_i;
    assign bus_width_o = wide_i;
    // Slow memory: ready withheld for wait_i cycles of each strobe
    assign ready_o     = act && (low_len >= int'(wait_i));

    always @(posedge clk_i)
    begin
        act_d <= act;
        // Released bus shows a changing pattern, never stale data
        ad_o  <= !read_low_i ? rdata_i : ~ad_o;
        if (!act)
        begin
            prev_ad <= ad_i;
            as_prev <= addr_strobe_i;
            low_len <= 0;
        end
        else
        begin
            low_len  <= low_len + 1;
            last_len <= low_len + 1;
            saw_wl   <= (act_d ? saw_wl : 1'b0) | !write_low_i;
            saw_hi   <= (act_d ? saw_hi : 1'b0) | !high_pin_i;
            saw_rd   <= (act_d ? saw_rd : 1'b0) | !read_low_i;
            fk_const <= (act_d ? fk_const && (fetch_kind_i === fk_first) : 1'b1);
            if (!act_d)
            begin
                cycles   <= cycles + 1;
                addr     <= prev_ad;
                as_addr  <= as_prev;
                fk_first <= fetch_kind_i;
            end
        end
    end
endmodule : embi_mem_model

/* File: testbench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, nmi_i = 0;
    logic        onchip_rom_select_i = 1, prog_pin_i = 0, reset_pin_i = 1, hold_req_i = 0;
    logic [3:0]  wb_adr_i = 0, wb_sel_i = 0, wait_n = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, exp_q[$], msk_q[$], got_v, exp_v, r;
    logic [31:0] seed = 32'h000133af;
    logic [15:0] ad_i, ad_o, ad_oe_o, vector_addr_o, rdata = 0, a;
    logic        wb_ack_o, bus_width_i, ready_i, clock_output_o, addr_strobe_o, read_low_o;
    logic        write_low_o, high_pin_o, fetch_kind_flag_o, bus_hold_grant_o, bus_request_out_o;
    logic        reset_pin_o, reset_pin_oe_o, nmi_vector_o, prog_mode_o, device_reset_o;
    logic        wide = 1, dyn, low_byte_write_strobe, hiw, odd, word, address_valid_low, ewl, ehi, co, intern;
    int          mismatches = 0, check_count = 0, n, c;

    embi_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_width_i, .ready_i, .nmi_i, .onchip_rom_select_i,
        .prog_pin_i, .reset_pin_i, .hold_req_i, .ad_i, .clock_output_o, .addr_strobe_o,
        .read_low_o, .write_low_o, .high_pin_o, .fetch_kind_flag_o, .bus_hold_grant_o,
        .bus_request_out_o, .reset_pin_o, .reset_pin_oe_o, .ad_o, .ad_oe_o, .nmi_vector_o,
        .vector_addr_o, .prog_mode_o, .device_reset_o);

    embi_mem_model mem_u (.clk_i, .addr_strobe_i(addr_strobe_o), .read_low_i(read_low_o),
        .write_low_i(write_low_o), .high_pin_i(high_pin_o), .fetch_kind_i(fetch_kind_flag_o),
        .ad_i(ad_o), .wait_i(wait_n), .rdata_i(rdata), .wide_i(wide), .ready_o(ready_i),
        .bus_width_o(bus_width_i), .ad_o(ad_i));

    always #20 clk_i = ~clk_i;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input logic [3:0] adr, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        wb(1'b0, adr, 32'h00000000);
    endtask : rd

    task automatic done_wait();
        repeat (2) @(posedge clk_i);
        while (bus_request_out_o !== 1'b0 || read_low_o !== 1'b1 || write_low_o !== 1'b1)
            @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask : done_wait

    task automatic op(input logic we, input logic fetch, input logic wd, input logic [15:0] ad);
        wb(1'b1, embi_pkg::OFF_REQUEST, {ad, 12'h000, wd, fetch, we, 1'b1});
        done_wait();
    endtask : op

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // Read results are judged only when the slave answers
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
        begin
            got_v = wb_dat_o & msk_q.pop_front();
            exp_v = exp_q.pop_front();
            `CHK(got_v, exp_v)
        end

    initial
    begin
        #1_000_000;
        mismatches++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK({read_low_o, write_low_o, high_pin_o, fetch_kind_flag_o}, 4'b1110)
        rd(embi_pkg::OFF_CONFIG, {24'h000000, embi_pkg::CONFIG_RESET}, 32'hffffffff);
        rd(4'h6, 32'h00000000, 32'hffffffff);
        for (int i = 0; i < 4; i++)
        begin
            co = clock_output_o;
            @(posedge clk_i);
            `CHK(clock_output_o, ~co)
        end
        for (int i = 0; i < 16; i++)
        begin
            r    = rnd();
            dyn  = i[0];
            low_byte_write_strobe  = i[1];
            hiw  = i[2];
            odd  = i[3];
            address_valid_low  = i[1] ^ i[3];
            word = !odd && (i[1] ^ i[2]);
            a    = {3'b101, r[12:1], odd};
            ewl  = !low_byte_write_strobe || !odd;
            ehi  = hiw ? (odd || (dyn && word && (i[2] | !odd))) :
                   (dyn && (i[2] | !odd) && (word || odd));
            if (!(ewl || ehi))
                continue;
            wide <= i[2] | !odd;
            wb(1'b1, embi_pkg::OFF_CONFIG, {27'h0000000, hiw, low_byte_write_strobe, address_valid_low, dyn, 1'b0});
            wb(1'b1, embi_pkg::OFF_DATA, r);
            op(1'b1, 1'b0, word, a);
            `CHK({mem_u.saw_wl, mem_u.saw_hi, mem_u.saw_rd}, {ewl, ehi, 1'b0})
            `CHK(mem_u.addr, a)
            `CHK({mem_u.as_addr, addr_strobe_o}, {!address_valid_low, address_valid_low})
        end
        wide <= 1'b1;
        wb(1'b1, embi_pkg::OFF_CONFIG, 32'h00000002);
        for (int j = 0; j < 6; j++)
        begin
            r = rnd();
            wait_n <= {1'b0, r[2:0]};
            rdata  <= r[31:16];
            op(1'b0, j[0], 1'b1, {3'b110, r[14:3], 1'b0});
            rd(embi_pkg::OFF_DATA, {r[31:16], 16'h0000}, 32'hffff0000);
            `CHK({mem_u.fk_first, mem_u.fk_const, mem_u.saw_rd, mem_u.saw_wl}, {j[0], 3'b110})
            `CHK(mem_u.last_len > int'(r[2:0]), 1'b1)
            `CHK(fetch_kind_flag_o, 1'b0)
        end
        for (int k = 0; k < 5; k++)
        begin
            a      = (k == 0) ? 16'h1fff : (k == 2) ? 16'h9fff : (k == 3) ? 16'ha000 : 16'h2000;
            intern = (k == 1 || k == 2);
            onchip_rom_select_i <= (k != 4);
            c = mem_u.cycles;
            op(1'b0, 1'b0, 1'b0, a);
            `CHK(mem_u.cycles - c, int'(!intern))
            if (intern)
                rd(embi_pkg::OFF_DATA, 32'hffff0000, 32'hffff0000);
        end
        prog_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(prog_mode_o, 1'b1)
        onchip_rom_select_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(prog_mode_o, 1'b0)
        nmi_i <= 1'b1;
        n = 0;
        repeat (10)
        begin
            @(posedge clk_i);
            if (nmi_vector_o === 1'b1)
                n++;
        end
        `CHK(n, 1)
        `CHK(vector_addr_o, 16'h203e)
        hold_req_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHK(bus_hold_grant_o, 1'b1)
        `CHK(ad_oe_o, 16'h0000)
        c = mem_u.cycles;
        wb(1'b1, embi_pkg::OFF_REQUEST, 32'hb0000001);
        repeat (6) @(posedge clk_i);
        `CHK({bus_request_out_o, mem_u.cycles == c}, 2'b11)
        hold_req_i <= 1'b0;
        done_wait();
        `CHK(mem_u.cycles - c, 1)
        wb(1'b1, embi_pkg::OFF_CONFIG, 32'h00000020);
        `CHK({reset_pin_oe_o, reset_pin_o}, 2'b10)
        reset_pin_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK(device_reset_o, 1'b1)
        reset_pin_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        `CHK(device_reset_o, 1'b0)
        stop_test();
    end
endmodule : tb
